//--- shared/spc_pkg.sv
// constants and types for the sector protection control block
//
// Overview of operation
// - enable command applied at chip-select rise
// - disable command applied at rise unless pin
// - software protection cleared at power-up reset
// - protected sectors refuse program and erase
// - asserted pin locks map and marked sectors
// - asserting pin enables protection within delay
// - releasing pin disables unless enable was seen
// - enable before or during pin survives release
// - disable ignored while pin is asserted
// - pin input filtered against short glitches
// - status shows protection enabled from either source
// - sixteen map bytes, FFh protects sectors 1-15
// - sector 0 bits 7:6 guard pages 0-7, bits 5:4 pages 8-255
package spc_pkg;
	localparam logic [7:0] CMD_B1      = 8'h3D;
	localparam logic [7:0] CMD_B2      = 8'h2A;
	localparam logic [7:0] CMD_B3      = 8'h7F;
	localparam logic [7:0] CMD_ENABLE  = 8'hA9;
	localparam logic [7:0] CMD_DISABLE = 8'h9A;
	localparam int         SECTORS     = 16;
	localparam logic [7:0] MAP_PROT    = 8'hFF;
	localparam int         SUB0A_HI    = 7;
	localparam int         SUB0B_HI    = 5;
	localparam logic [1:0] SUB_PROT    = 2'h3;
	localparam logic [7:0] SUB0A_LAST_PAGE = 8'h07;
	localparam int         CLOCK_MHZ   = 10;
	localparam int         ASSERT_DELAY_NS  = 1000;
	localparam int         RELEASE_DELAY_NS = 1000;
	localparam int         FILTER_CYCLES    = 4;
	// longest times round down, never below one cycle
	localparam int ASSERT_CYC_RAW  = ASSERT_DELAY_NS * CLOCK_MHZ / 1000;
	localparam int RELEASE_CYC_RAW = RELEASE_DELAY_NS * CLOCK_MHZ / 1000;
	localparam int ASSERT_CYCLES   = (ASSERT_CYC_RAW < 1) ? 1 : ASSERT_CYC_RAW;
	localparam int RELEASE_CYCLES  = (RELEASE_CYC_RAW < 1) ? 1 : RELEASE_CYC_RAW;
	localparam int CNT_W           = 8;
	typedef enum logic [1:0] {ACT_NONE, ACT_ENABLE, ACT_DISABLE} spc_act_t;
endpackage : spc_pkg

//--- rtl/spc_link.sv
// serial command receiver on the link clock
`timescale 1ns/1ns
module spc_link
(
	input  wire logic             sck,
	input  wire logic             cs_n,
	input  wire logic             mosi,
	output      logic             done_toggle,
	output      spc_pkg::spc_act_t done_act
);
	import spc_pkg::*;
	logic [2:0]  bit_cnt;
	logic [2:0]  byte_cnt;
	logic [6:0]  shift;
	logic [2:0]  prefix_ok;
	logic [7:0]  next_byte;
	spc_act_t    act;
	assign next_byte = {shift, mosi};
	// cs_n acts as async reset so each frame restarts cleanly with no extra sck edges
	always_ff @(posedge sck or posedge cs_n)
	begin
		if (cs_n)
		begin
			bit_cnt   <= 3'h0;
			byte_cnt  <= 3'h0;
			shift     <= 7'h00;
			prefix_ok <= 3'h0;
			act       <= ACT_NONE;
		end
		else
		begin
			shift   <= next_byte[6:0];
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7)
			begin
				if (byte_cnt != 3'h7)
					byte_cnt <= byte_cnt + 3'h1;
				unique case (byte_cnt)
					3'h0: prefix_ok[0] <= (next_byte == CMD_B1);
					3'h1: prefix_ok[1] <= (next_byte == CMD_B2);
					3'h2: prefix_ok[2] <= (next_byte == CMD_B3);
					3'h3:
					begin
						// unknown fourth byte leaves no action
						if (&prefix_ok && next_byte == CMD_ENABLE)
							act <= ACT_ENABLE;
						else if (&prefix_ok && next_byte == CMD_DISABLE)
							act <= ACT_DISABLE;
						else
							act <= ACT_NONE;
					end
					default: act <= ACT_NONE;
				endcase
			end
			else if (byte_cnt >= 3'h4)
				act <= ACT_NONE;
		end
	end
	// a bit past the fourth byte spoils the command; act only on exact length
	// latched at cs rise in the link domain as toggle plus stable word
	logic exact;
	// no reset pin reaches this domain, so power-up values come from the declarations
	logic     tog  = 1'b0;
	spc_act_t word = ACT_NONE;
	assign exact = (byte_cnt == 3'h4) && (bit_cnt == 3'h0);
	always_ff @(posedge cs_n)
	begin
		if (exact && act != ACT_NONE)
		begin
			word <= act;
			tog  <= ~tog;
		end
	end
	assign done_toggle = tog;
	assign done_act    = word;
endmodule : spc_link

//--- rtl/spc_ctrl.sv
// sector protection control: command crossing, pin filter, state and gating
`timescale 1ns/1ns
module spc_ctrl
(
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        sck,
	input  wire logic        cs_n,
	input  wire logic        mosi,
	input  wire logic        wp_n,
	input  wire logic        op_req,
	input  wire logic        op_is_map,
	input  wire logic [3:0]  op_sector,
	input  wire logic [7:0]  op_page,
	input  wire logic        map_we,
	input  wire logic [3:0]  map_addr,
	input  wire logic [7:0]  map_wdata,
	output      logic        op_grant,
	output      logic        op_refuse,
	output      logic        status_protect,
	output      logic        map_ro
);
	import spc_pkg::*;
	logic        link_toggle;
	spc_act_t    link_act;
	logic [2:0]  tog_sync;
	logic        cmd_pulse;
	spc_act_t    cmd_act;
	logic        wp_s1;
	logic        wp_s2;
	logic [CNT_W-1:0] flt_cnt;
	logic        wp_filt;
	logic        wp_held;
	logic [CNT_W-1:0] dly_cnt;
	logic        sw_prot;
	logic        prot_on;
	logic [7:0]  prot_map [SECTORS];
	logic        sect_marked;
	logic        next_refuse;
	spc_link u_link
	(
		.sck         (sck),
		.cs_n        (cs_n),
		.mosi        (mosi),
		.done_toggle (link_toggle),
		.done_act    (link_act)
	);
	// toggle crossing; the action word is stable long before the toggle is seen
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			tog_sync <= 3'h0;
		else
			tog_sync <= {tog_sync[1:0], link_toggle};
	end
	assign cmd_pulse = tog_sync[2] ^ tog_sync[1];
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			cmd_act <= ACT_NONE;
		else if (tog_sync[1] != tog_sync[2])
			cmd_act <= link_act;
	end
	logic cmd_seen;
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			cmd_seen <= 1'b0;
		else
			cmd_seen <= cmd_pulse;
	end
	// pin synchroniser
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wp_s1 <= 1'b1;
			wp_s2 <= 1'b1;
		end
		else
		begin
			wp_s1 <= wp_n;
			wp_s2 <= wp_s1;
		end
	end
	// glitch filter: a level must hold for a run before it is believed
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			flt_cnt <= '0;
			wp_filt <= 1'b0;
		end
		else if ((~wp_s2) == wp_filt)
			flt_cnt <= '0;
		else if (flt_cnt == CNT_W'(FILTER_CYCLES - 1))
		begin
			flt_cnt <= '0;
			wp_filt <= ~wp_s2;
		end
		else
			flt_cnt <= flt_cnt + 1'b1;
	end
	// filtered level then waits out the rest of the assert or release delay, less synchroniser and filter cycles, before taking effect
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dly_cnt <= '0;
			wp_held <= 1'b0;
		end
		else if (wp_filt == wp_held)
			dly_cnt <= '0;
		else if (wp_filt && dly_cnt == CNT_W'(ASSERT_CYCLES - FILTER_CYCLES - 2))
		begin
			dly_cnt <= '0;
			wp_held <= 1'b1;
		end
		else if (!wp_filt && dly_cnt == CNT_W'(RELEASE_CYCLES - FILTER_CYCLES - 2))
		begin
			dly_cnt <= '0;
			wp_held <= 1'b0;
		end
		else
			dly_cnt <= dly_cnt + 1'b1;
	end
	// software state; reset models power-up
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			sw_prot <= 1'b0;
		else if (cmd_seen && cmd_act == ACT_ENABLE)
			sw_prot <= 1'b1;
		else if (cmd_seen && cmd_act == ACT_DISABLE && !wp_held)
			sw_prot <= 1'b0;
	end
	// pin overrides only upward; release returns to the software state
	assign prot_on = sw_prot | wp_held;
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			status_protect <= 1'b0;
			map_ro         <= 1'b0;
		end
		else
		begin
			status_protect <= prot_on;
			map_ro         <= wp_held;
		end
	end
	// map writes are dropped while the pin holds; no flash timing is modelled here
	genvar g;
	generate
		for (g = 0; g < SECTORS; g++)
		begin : g_map
			always_ff @(posedge clock or negedge arst_n)
			begin
				if (!arst_n)
					prot_map[g] <= 8'h00;
				else if (map_we && !wp_held && map_addr == 4'(g))
					prot_map[g] <= map_wdata;
			end
		end
	endgenerate
	always_comb
	begin
		if (op_sector == 4'h0)
		begin
			if (op_page <= SUB0A_LAST_PAGE)
				sect_marked = (prot_map[0][SUB0A_HI -: 2] == SUB_PROT);
			else
				sect_marked = (prot_map[0][SUB0B_HI -: 2] == SUB_PROT);
		end
		else
			sect_marked = (prot_map[op_sector] == MAP_PROT);
	end
	always_comb
	begin
		if (op_is_map)
			next_refuse = wp_held;
		else
			next_refuse = prot_on && sect_marked;
	end
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			op_grant  <= 1'b0;
			op_refuse <= 1'b0;
		end
		else
		begin
			op_grant  <= op_req && !next_refuse;
			op_refuse <= op_req && next_refuse;
		end
	end
endmodule : spc_ctrl

//--- bench/spc_host.sv
// serial host model sending four-byte commands
`timescale 1ns/1ns
module spc_host
(
	output logic sck,
	output logic cs_n,
	output logic mosi
);
	initial
	begin
		{sck, cs_n, mosi} = 3'b010;
	end
	// mode 0, sck idles low and stands still between frames
	task send(input logic [31:0] w);
		cs_n = 0;
		for (int i = 31; i >= 0; i--)
		begin
			mosi = w[i];
			#24 sck = 1;
			#24 sck = 0;
		end
		#24 cs_n = 1;
		mosi = ~mosi; // no pull on the line, so never leave it looking held
	endtask : send
endmodule : spc_host

//--- bench/spc_ctrl_checker.sv
// port assertions for the sector protection control
`timescale 1ns/1ns
module spc_ctrl_checker
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic cs_n,
	input wire logic wp_n,
	input wire logic op_req,
	input wire logic op_is_map,
	input wire logic op_grant,
	input wire logic op_refuse,
	input wire logic status_protect,
	input wire logic map_ro
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	chk_one_answer: assert property (op_req |=> op_grant ^ op_refuse)
		else $error("request not answered once");
	chk_no_spurious: assert property (!op_req |=> !op_grant && !op_refuse)
		else $error("answer without request");
	chk_map_locked: assert property (op_req && op_is_map && map_ro |=> op_refuse)
		else $error("map change allowed while pin held");
	chk_pin_enables: assert property ($fell(wp_n) ##1 !wp_n[*8] |-> ##[0:12] map_ro && status_protect)
		else $error("held pin did not protect");
	chk_glitch_ignored: assert property (!map_ro && $fell(wp_n) ##2 $rose(wp_n) |-> !map_ro[*8])
		else $error("pin glitch passed the filter");
	chk_disable_held: assert property (map_ro && status_protect ##1 map_ro |-> status_protect)
		else $error("protection dropped while pin held");
	chk_free_grant: assert property (op_req && !status_protect && !map_ro |=> op_grant || status_protect)
		else $error("refused while unprotected");
	chk_cmd_quiet: assert property ((!cs_n && wp_n)[*8] |-> !$rose(status_protect))
		else $error("protection rose inside a frame");
	cover property (op_req ##1 op_refuse);
	cover property ($rose(status_protect) && wp_n);
	cover property ($rose(map_ro));
endmodule : spc_ctrl_checker
bind spc_ctrl spc_ctrl_checker chk (.*);

//--- bench/spc_ctrl_tb.sv
// self-checking bench for the sector protection control
`timescale 1ns/1ns
module spc_ctrl_tb;
	import spc_pkg::*;
	logic       clock, arst_n, wp_n, op_req, op_is_map, map_we;
	logic       sck, cs_n, mosi, op_grant, op_refuse, status_protect, map_ro;
	logic [3:0] op_sector, map_addr;
	logic [7:0] op_page, map_wdata;
	int         bad_count, tests_run, cycles;
	spc_host host (.sck(sck), .cs_n(cs_n), .mosi(mosi));
	spc_ctrl dut (.clock(clock), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n),
		.op_req(op_req), .op_is_map(op_is_map), .op_sector(op_sector), .op_page(op_page), .map_we(map_we),
		.map_addr(map_addr), .map_wdata(map_wdata), .op_grant(op_grant), .op_refuse(op_refuse),
		.status_protect(status_protect), .map_ro(map_ro));
	initial
	begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	task check(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	task op(input logic m, input logic [3:0] s, input logic [7:0] p, input logic ok);
		@(negedge clock);
		{op_req, op_is_map, op_sector, op_page} = {1'b1, m, s, p};
		@(negedge clock);
		op_req = 0;
		check(op_grant, ok);
		check(op_refuse, !ok);
	endtask : op
	task mw(input logic [3:0] a, input logic [7:0] d);
		@(negedge clock);
		{map_we, map_addr, map_wdata} = {1'b1, a, d};
		@(negedge clock);
		map_we = 0;
	endtask : mw
	// fixed settle time covers the crossing after cs_n rises
	task cmd(input logic [7:0] last);
		host.send({CMD_B1, CMD_B2, CMD_B3, last});
		cyc(12);
	endtask : cmd
	task pin(input logic v, input int n);
		@(negedge clock);
		wp_n = v;
		cyc(n);
	endtask : pin
	task sc_soft;
		check(status_protect, 1'b0);
		mw(4'h3, MAP_PROT);
		mw(4'h0, 8'hC5);
		op(1'b0, 4'h3, 8'h00, 1'b1);
		op(1'b1, 4'h0, 8'h00, 1'b1);
		cmd(CMD_ENABLE);
		check(status_protect, 1'b1);
		op(1'b0, 4'h3, 8'h00, 1'b0);
		op(1'b0, 4'h4, 8'h00, 1'b1);
		op(1'b0, 4'h0, 8'h07, 1'b0);
		op(1'b0, 4'h0, 8'h08, 1'b1);
		mw(4'h0, 8'h3A);
		op(1'b0, 4'h0, 8'h07, 1'b1);
		op(1'b0, 4'h0, 8'hFF, 1'b0);
		cmd(8'h55);
		check(status_protect, 1'b1);
		cmd(CMD_DISABLE);
		check(status_protect, 1'b0);
	endtask : sc_soft
	task sc_pin;
		pin(1'b0, 2);
		pin(1'b1, 20);
		check(status_protect, 1'b0);
		pin(1'b0, 20);
		check(status_protect, 1'b1);
		check(map_ro, 1'b1);
		op(1'b1, 4'h0, 8'h00, 1'b0);
		cmd(CMD_DISABLE);
		check(status_protect, 1'b1);
		pin(1'b1, 20);
		check(status_protect, 1'b0);
	endtask : sc_pin
	task sc_hold;
		pin(1'b0, 20);
		cmd(CMD_ENABLE);
		mw(4'h3, 8'h00);
		pin(1'b1, 20);
		check(status_protect, 1'b1);
		op(1'b0, 4'h3, 8'h00, 1'b0);
		cmd(CMD_DISABLE);
		check(status_protect, 1'b0);
	endtask : sc_hold
	task close_out;
		$display("checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			close_out;
		end
	end
	initial
	begin
		{arst_n, wp_n, op_req, op_is_map, map_we} = 5'b01000;
		{op_sector, op_page, map_addr, map_wdata} = 24'h000000;
		cyc(20);
		arst_n = 1;
		sc_soft;
		sc_pin;
		sc_hold;
		close_out;
	end
endmodule : spc_ctrl_tb
